// ### logic/isio_map.vh
// Register map, field positions and reset values of the interrupt status
// and output block. Assumes word-indexed registers on a 32-bit bus.
`ifndef ISIO_MAP_VH
`define ISIO_MAP_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define ISIO_IDX_HP_OFF_DONE   16'h198D
`define ISIO_IDX_PIN_LEVEL     16'h1990
`define ISIO_IDX_EVLOG_NE      16'h1995
`define ISIO_IDX_EVLOG_FULL    16'h1996
`define ISIO_IDX_EVLOG_WMARK   16'h1997
`define ISIO_IDX_DSP_DMA       16'h1998
`define ISIO_IDX_DSP_BUSY      16'h199D
`define ISIO_IDX_ALARM         16'h19A3
`define ISIO_IDX_LINE1_CTRL    16'h1A80
`define ISIO_IDX_LINE2_CTRL    16'h1A82
`define ISIO_IDX_SUMMARY       16'h1AA0
`define ISIO_IDX_EV_STATUS     16'h1AB0
`define ISIO_IDX_EV_CLEAR      16'h1AB1
`define ISIO_IDX_EV_ENABLE     16'h1AB2

// ==========================================================================
// Field positions
`define ISIO_BIT_MASK          11
`define ISIO_BIT_POL           10
`define ISIO_BIT_DRIVE         9

// ==========================================================================
// Reset values
`define ISIO_LINE1_RST         16'h0400
`define ISIO_LINE2_RST         16'h0000
`define ISIO_UNMAPPED_DATA     32'hDEAD_0000

`endif

// ### logic/isio_pin_drive.v
// One interrupt output pin: polarity and push-pull or open-drain drive.
// Assumes a two-signal pin resolved outside the design.
`timescale 1ns/1ps
module isio_pin_drive (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Control
    input  wire active_i,
    input  wire active_low_i,
    input  wire open_drain_i,
    // Pin
    output reg  pin_o,
    output reg  pin_oe_o
);
    wire lvl;
    assign lvl = active_i ^ active_low_i;

    // ======================================================================
    // Output stage
    // assert per polarity.
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o    <= 1'b1;
            pin_oe_o <= 1'b1;
        end else begin
            pin_o <= lvl;
            pin_oe_o <= open_drain_i ? ~lvl : 1'b1;
        end
    end
endmodule

// ### logic/isio_top.v
// Interrupt status and interrupt output lines for the second status set,
// with a classic Wishbone register slave.
// Assumes status sources are synchronous to clk_i.
//
// Operation
// - Headphone disable done flag reads 0 while sequence runs, 1 when idle.
// - Sixteen pin levels readable, pin sixteen at bit 15, pin one bit 0.
// - Pin level valid only for plain inputs; DSP-owned pins read zero.
// - Event log not-empty bit reads 1 while FIFO holds an entry.
// - Event log full bit reads 1 while FIFO is full.
// - Event log watermark bit reads 1 once level reached watermark.
// - DSP transfer done reads 1 when all enabled buffers filled or emptied.
// - Alarm one channels one to four at bits 0 to 3, 1 while asserted.
// - Line one mask bit 11 suppresses line one, resets unmasked.
// - Bit 10 polarity, reset active low; bit 9 selects open drain.
// - Line two mask bit 11 suppresses line two, resets unmasked.
// - Summary bit 1 is OR of unmasked set two event flags.
// - Summary bit 0 is OR of unmasked set one event flags.
`timescale 1ns/1ps
`include "isio_map.vh"
module isio_top (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [17:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Status sources
    input  wire [5:0]  hp_off_busy_i,
    input  wire [15:0] pin_level_i,
    input  wire [15:0] pin_is_input_i,
    input  wire [15:0] dsp_owned_pin_i,
    input  wire [4:0]  evlog_count_i,
    input  wire [4:0]  evlog_depth_i,
    input  wire [4:0]  evlog_wmark_i,
    input  wire [7:0]  write_transfer_en_i,
    input  wire [7:0]  write_transfer_full_i,
    input  wire [7:0]  read_transfer_en_i,
    input  wire [7:0]  read_transfer_empty_i,
    input  wire        dsp_executing_i,
    input  wire [3:0]  alarm_one_i,
    // Event flags of both sets, already masked per source
    input  wire [31:0] set_one_event_flag_i,
    input  wire [31:0] set_two_event_flag_i,
    // Interrupt pins
    output wire        line_one_o,
    output wire        line_one_oe_o,
    output wire        line_two_o,
    output wire        line_two_oe_o,
    // Block interrupt
    output reg         irq_o
);
    // ======================================================================
    // Registers
    reg  [5:0]  hp_off_complete_reg;
    reg  [15:0] pin_level_reg;
    reg         evlog_has_entries_reg;
    reg         evlog_full_flag_reg;
    reg         evlog_level_reached_reg;
    reg         dsp_transfer_done_reg;
    reg         dsp_running_flag_reg;
    reg  [3:0]  alarm_one_reg;
    reg  [15:0] line1_ctrl_reg;
    reg  [15:0] line2_ctrl_reg;
    reg  [1:0]  summary_reg;
    reg  [1:0]  line_active_reg;
    reg  [7:0]  ev_status_reg;
    reg  [7:0]  ev_enable_reg;
    reg  [7:0]  ev_prev_reg;
    reg  [31:0] rd_next;
    wire [7:0]  ev_level;
    wire [7:0]  ev_rise;
    wire        access;
    wire [15:0] idx;
    wire        wr_clear;

    // Returns 1 when the request addresses register index i.
    function hit;
        input [15:0] a;
        input [15:0] i;
        begin
            hit = (a == i);
        end
    endfunction

    assign access   = cyc_i & stb_i & ~ack_o;
    assign idx      = adr_i[17:2];
    assign wr_clear = access & we_i & sel_i[0]
                      & hit(idx, `ISIO_IDX_EV_CLEAR);

    // ======================================================================
    // Raw status capture
    always @(posedge clk_i) begin
        if (rst_i) begin
            hp_off_complete_reg     <= 6'h00;
            pin_level_reg           <= 16'h0000;
            evlog_has_entries_reg   <= 1'b0;
            evlog_full_flag_reg     <= 1'b0;
            evlog_level_reached_reg <= 1'b0;
            dsp_transfer_done_reg   <= 1'b0;
            dsp_running_flag_reg    <= 1'b0;
            alarm_one_reg           <= 4'h0;
            summary_reg             <= 2'b00;
        end else begin
            hp_off_complete_reg <= ~hp_off_busy_i;
            pin_level_reg <= pin_level_i & pin_is_input_i
                             & ~dsp_owned_pin_i;
            evlog_has_entries_reg <= (evlog_count_i != 5'h00);
            evlog_full_flag_reg <= (evlog_count_i >= evlog_depth_i);
            evlog_level_reached_reg <= (evlog_count_i >= evlog_wmark_i);
            dsp_transfer_done_reg <=
                ((write_transfer_en_i & ~write_transfer_full_i) == 8'h00)
                && ((read_transfer_en_i & ~read_transfer_empty_i) == 8'h00);
            dsp_running_flag_reg <= dsp_executing_i;
            alarm_one_reg <= alarm_one_i;
            summary_reg <= {|set_two_event_flag_i, |set_one_event_flag_i};
        end
    end

    // ======================================================================
    // Line activity: summary gated by each line mask
    always @(posedge clk_i) begin
        if (rst_i) begin
            line_active_reg <= 2'b00;
        end else begin
            line_active_reg[0] <= summary_reg[0]
                                  & ~line1_ctrl_reg[`ISIO_BIT_MASK];
            line_active_reg[1] <= summary_reg[1]
                                  & ~line2_ctrl_reg[`ISIO_BIT_MASK];
        end
    end

    // Both lines share the polarity and drive settings of line one control.
    isio_pin_drive u_line_one (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .active_i     (line_active_reg[0]),
        .active_low_i (line1_ctrl_reg[`ISIO_BIT_POL]),
        .open_drain_i (line1_ctrl_reg[`ISIO_BIT_DRIVE]),
        .pin_o        (line_one_o),
        .pin_oe_o     (line_one_oe_o)
    );

    isio_pin_drive u_line_two (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .active_i     (line_active_reg[1]),
        .active_low_i (line1_ctrl_reg[`ISIO_BIT_POL]),
        .open_drain_i (line1_ctrl_reg[`ISIO_BIT_DRIVE]),
        .pin_o        (line_two_o),
        .pin_oe_o     (line_two_oe_o)
    );

    // ======================================================================
    // Sticky events: rising edges of the status bits
    assign ev_level = {summary_reg, dsp_transfer_done_reg,
                       evlog_level_reached_reg, evlog_full_flag_reg,
                       evlog_has_entries_reg, |alarm_one_reg,
                       &hp_off_complete_reg};
    assign ev_rise  = ev_level & ~ev_prev_reg;

    // A new edge wins over a clear in the same cycle so no event is lost.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ev_prev_reg   <= 8'h00;
            ev_status_reg <= 8'h00;
            irq_o         <= 1'b0;
        end else begin
            ev_prev_reg   <= ev_level;
            ev_status_reg <= (ev_status_reg
                              & ~(wr_clear ? dat_i[7:0] : 8'h00))
                             | ev_rise;
            irq_o         <= |(ev_status_reg & ev_enable_reg);
        end
    end

    // ======================================================================
    // Wishbone writes
    // Only the low byte lanes matter; all registers are 16 bits or less.
    always @(posedge clk_i) begin
        if (rst_i) begin
            line1_ctrl_reg <= `ISIO_LINE1_RST;
            line2_ctrl_reg <= `ISIO_LINE2_RST;
            ev_enable_reg  <= 8'h00;
        end else if (access && we_i) begin
            if (hit(idx, `ISIO_IDX_LINE1_CTRL)) begin
                if (sel_i[1]) begin
                    line1_ctrl_reg[15:8] <= dat_i[15:8];
                end
                if (sel_i[0]) begin
                    line1_ctrl_reg[7:0] <= dat_i[7:0];
                end
            end else if (hit(idx, `ISIO_IDX_LINE2_CTRL)) begin
                if (sel_i[1]) begin
                    line2_ctrl_reg[15:8] <= dat_i[15:8];
                end
                if (sel_i[0]) begin
                    line2_ctrl_reg[7:0] <= dat_i[7:0];
                end
            end else if (hit(idx, `ISIO_IDX_EV_ENABLE)) begin
                if (sel_i[0]) begin
                    ev_enable_reg <= dat_i[7:0];
                end
            end
        end
    end

    // ======================================================================
    // Wishbone read decode
    always @* begin
        rd_next = 32'h0000_0000;
        if (hit(idx, `ISIO_IDX_HP_OFF_DONE)) begin
            rd_next[5:0] = hp_off_complete_reg;
        end else if (hit(idx, `ISIO_IDX_PIN_LEVEL)) begin
            rd_next[15:0] = pin_level_reg;
        end else if (hit(idx, `ISIO_IDX_EVLOG_NE)) begin
            rd_next[0] = evlog_has_entries_reg;
        end else if (hit(idx, `ISIO_IDX_EVLOG_FULL)) begin
            rd_next[0] = evlog_full_flag_reg;
        end else if (hit(idx, `ISIO_IDX_EVLOG_WMARK)) begin
            rd_next[0] = evlog_level_reached_reg;
        end else if (hit(idx, `ISIO_IDX_DSP_DMA)) begin
            rd_next[0] = dsp_transfer_done_reg;
        end else if (hit(idx, `ISIO_IDX_DSP_BUSY)) begin
            rd_next[0] = dsp_running_flag_reg;
        end else if (hit(idx, `ISIO_IDX_ALARM)) begin
            rd_next[3:0] = alarm_one_reg;
        end else if (hit(idx, `ISIO_IDX_LINE1_CTRL)) begin
            rd_next[15:0] = line1_ctrl_reg;
        end else if (hit(idx, `ISIO_IDX_LINE2_CTRL)) begin
            rd_next[15:0] = line2_ctrl_reg;
        end else if (hit(idx, `ISIO_IDX_SUMMARY)) begin
            rd_next[1:0] = summary_reg;
        end else if (hit(idx, `ISIO_IDX_EV_STATUS)) begin
            rd_next[7:0] = ev_status_reg;
        end else if (hit(idx, `ISIO_IDX_EV_ENABLE)) begin
            rd_next[7:0] = ev_enable_reg;
        end else if (hit(idx, `ISIO_IDX_EV_CLEAR)) begin
            rd_next = 32'h0000_0000;
        end else begin
            rd_next = `ISIO_UNMAPPED_DATA;
        end
    end

    // One wait state: ack one edge after the request, then dropped.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= access;
            if (access && !we_i) begin
                dat_o <= rd_next;
            end
        end
    end
endmodule

// ### bench/isio_asserts.sv
// Checker for the interrupt status and output block.
// Assumes whole-word register writes; sees only the top-level ports.
`timescale 1ns/1ps
`include "isio_map.vh"
module isio_asserts (
    // Clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // Bus
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [17:0] adr_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    // Events and pins
    input wire [31:0] set_one_event_flag_i,
    input wire [31:0] set_two_event_flag_i,
    input wire        line_one_o,
    input wire        line_one_oe_o,
    input wire        line_two_o,
    input wire        irq_o
);
    // ======================================================================
    // Shadow controls; pins are judged only after three quiet cycles.
    reg  [15:0] c1_reg;
    reg  [15:0] c2_reg;
    reg  [1:0]  quiet_reg;
    wire        a1  = |set_one_event_flag_i;
    wire        a2  = |set_two_event_flag_i;
    wire        on1 = a1 & ~c1_reg[11];
    wire        on2 = a2 & ~c2_reg[11];
    wire        wr  = ack_o & we_i;
    wire [15:0] idx = adr_i[17:2];
    wire        q3  = (quiet_reg == 2'h3);
    always @(posedge clk_i) begin
        if (rst_i) begin
            c1_reg    <= `ISIO_LINE1_RST;
            c2_reg    <= `ISIO_LINE2_RST;
            quiet_reg <= 2'h0;
        end else begin
            if (wr && idx == `ISIO_IDX_LINE1_CTRL)
                c1_reg <= dat_i[15:0];
            if (wr && idx == `ISIO_IDX_LINE2_CTRL)
                c2_reg <= dat_i[15:0];
            quiet_reg <= wr ? 2'h0 : (q3 ? quiet_reg : quiet_reg + 2'h1);
        end
    end
    // ======================================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_take_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after request");
    ack_single_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    reset_idle_a: assert property (
        $fell(rst_i) |-> !ack_o && !irq_o && line_one_o && line_one_oe_o)
        else $error("outputs not idle after reset");
    sum_read_a: assert property (
        ack_o && !we_i && idx == `ISIO_IDX_SUMMARY &&
        $past(a1) == $past(a1, 2) && $past(a2) == $past(a2, 2)
        |-> dat_o[1:0] == {$past(a2), $past(a1)})
        else $error("summary read wrong");
    line_one_on_a: assert property (
        (on1 && q3)[*3] |=> line_one_o == !c1_reg[10])
        else $error("line one not asserted");
    line_one_off_a: assert property (
        (!on1 && q3)[*3] |=> line_one_o == c1_reg[10])
        else $error("line one not idle");
    line_two_on_a: assert property (
        (on2 && q3)[*3] |=> line_two_o == !c1_reg[10])
        else $error("line two not asserted");
    line_two_off_a: assert property (
        (!on2 && q3)[*3] |=> line_two_o == c1_reg[10])
        else $error("line two not idle");
    drive_type_a: assert property (
        q3[*3] |=> line_one_oe_o == (!c1_reg[9] || !line_one_o))
        else $error("line one drive enable wrong");
endmodule
bind isio_top isio_asserts chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .set_one_event_flag_i(set_one_event_flag_i),
    .set_two_event_flag_i(set_two_event_flag_i),
    .line_one_o(line_one_o), .line_one_oe_o(line_one_oe_o),
    .line_two_o(line_two_o), .irq_o(irq_o));

// ### bench/isio_host_model.sv
// Host side of the two interrupt pins: resolves each wire.
// Assumes a pull-up on both lines, so a released line reads high.
`timescale 1ns/1ps
module isio_host_model (
    // Pins from the device
    input  wire pin_one_i,
    input  wire pin_one_oe_i,
    input  wire pin_two_i,
    input  wire pin_two_oe_i,
    // Levels seen by the host
    output wire level_one_o,
    output wire level_two_o
);
    assign level_one_o = pin_one_oe_i ? pin_one_i : 1'b1;
    assign level_two_o = pin_two_oe_i ? pin_two_i : 1'b1;
endmodule

// ### bench/isio_top_bench.sv
// Bench for the interrupt status and output block.
// Assumes the register map header is on the include path.
`timescale 1ns/1ps
`include "isio_map.vh"
module isio_top_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic we_i = 1'b0, dsp_executing_i = 1'b0;
    logic [17:0] adr_i = 18'h0_0000;
    logic [31:0] dat_i = 32'h0000_0000, rdat, dat_o;
    logic [5:0]  hp_off_busy_i = 6'h3F;
    logic [15:0] pin_level_i = 16'h0000, pin_is_input_i = 16'h0000;
    logic [15:0] dsp_owned_pin_i = 16'h0000;
    logic [4:0]  evlog_count_i = 5'h00, evlog_wmark_i = 5'h04;
    logic [7:0]  wt_en = 8'h00, wt_full = 8'h00;
    logic [7:0]  rt_en = 8'h00, rt_empty = 8'h00;
    logic [3:0]  alarm_one_i = 4'h0;
    logic [31:0] f1 = 32'h0000_0000, f2 = 32'h0000_0000;
    logic ack_o, l1, l1_oe, l2, l2_oe, irq_o, lvl1, lvl2;
    integer fail_count = 0, num_checks = 0;
    initial forever #2.5 clk_i = ~clk_i;
    isio_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .hp_off_busy_i(hp_off_busy_i), .pin_level_i(pin_level_i),
        .pin_is_input_i(pin_is_input_i), .dsp_owned_pin_i(dsp_owned_pin_i),
        .evlog_count_i(evlog_count_i), .evlog_depth_i(5'h08),
        .evlog_wmark_i(evlog_wmark_i), .write_transfer_en_i(wt_en),
        .write_transfer_full_i(wt_full), .read_transfer_en_i(rt_en),
        .read_transfer_empty_i(rt_empty), .dsp_executing_i(dsp_executing_i),
        .alarm_one_i(alarm_one_i), .set_one_event_flag_i(f1),
        .set_two_event_flag_i(f2), .line_one_o(l1), .line_one_oe_o(l1_oe),
        .line_two_o(l2), .line_two_oe_o(l2_oe), .irq_o(irq_o));
    isio_host_model host_u (.pin_one_i(l1), .pin_one_oe_i(l1_oe),
        .pin_two_i(l2), .pin_two_oe_i(l2_oe), .level_one_o(lvl1),
        .level_two_o(lvl2));
    // ======================================================================
    // Tasks
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task wb(input [15:0] idx, input w, input [15:0] d);
        integer n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'h0};
        dat_i <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n = n + 1;
        end while (ack_o !== 1'b1 && n < 20);
        rdat = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20) begin
            fail_count = fail_count + 1;
            stop_test;
        end
    endtask
    task chk(input [15:0] idx, input [31:0] e);
        wb(idx, 1'b0, 16'h0000);
        num_checks = num_checks + 1;
        if (rdat !== e) begin
            fail_count = fail_count + 1;
            $display("unexpected reg %h exp %h got %h", idx, e, rdat);
        end
    endtask
    task chkb(input e, input g, input string nm);
        num_checks = num_checks + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("unexpected %s exp %b got %b", nm, e, g);
        end
    endtask
    // The pin path is three edges long, so four cycles always settle it.
    task settle;
        repeat (4) @(posedge clk_i);
    endtask
    task ev(input [4:0] c, input [2:0] e);
        @(posedge clk_i);
        evlog_count_i <= c;
        chk(`ISIO_IDX_EVLOG_NE, {31'h0, e[0]});
        chk(`ISIO_IDX_EVLOG_FULL, {31'h0, e[1]});
        chk(`ISIO_IDX_EVLOG_WMARK, {31'h0, e[2]});
    endtask
    // ======================================================================
    // Sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(`ISIO_IDX_LINE1_CTRL, 32'h0000_0400);
        chk(`ISIO_IDX_LINE2_CTRL, 32'h0000_0000);
        chk(`ISIO_IDX_SUMMARY, 32'h0000_0000);
        chk(16'h1234, `ISIO_UNMAPPED_DATA);
        @(posedge clk_i);
        hp_off_busy_i <= 6'h2A;
        pin_level_i <= 16'hA5C3;
        pin_is_input_i <= 16'h0FFF;
        dsp_owned_pin_i <= 16'h00F0;
        alarm_one_i <= 4'h9;
        dsp_executing_i <= 1'b1;
        wt_en <= 8'h03;
        wt_full <= 8'h03;
        rt_en <= 8'h04;
        rt_empty <= 8'h04;
        chk(`ISIO_IDX_HP_OFF_DONE, 32'h0000_0015);
        chk(`ISIO_IDX_PIN_LEVEL, 32'h0000_0503);
        chk(`ISIO_IDX_ALARM, 32'h0000_0009);
        chk(`ISIO_IDX_DSP_BUSY, 32'h0000_0001);
        chk(`ISIO_IDX_DSP_DMA, 32'h0000_0001);
        @(posedge clk_i);
        wt_full <= 8'h01;
        dsp_executing_i <= 1'b0;
        chk(`ISIO_IDX_DSP_DMA, 32'h0000_0000);
        chk(`ISIO_IDX_DSP_BUSY, 32'h0000_0000);
        ev(5'h04, 3'h5);
        ev(5'h08, 3'h7);
        chkb(1'b1, lvl1, "line one");
        f1 <= 32'h0000_0020;
        settle;
        chkb(1'b0, lvl1, "line one");
        chk(`ISIO_IDX_SUMMARY, 32'h0000_0001);
        wb(`ISIO_IDX_LINE1_CTRL, 1'b1, 16'h0C00);
        settle;
        chkb(1'b1, lvl1, "line one");
        wb(`ISIO_IDX_LINE1_CTRL, 1'b1, 16'h0000);
        settle;
        chkb(1'b1, lvl1, "line one");
        chkb(1'b0, lvl2, "line two");
        f2 <= 32'h8000_0000;
        settle;
        chkb(1'b1, lvl2, "line two");
        chk(`ISIO_IDX_SUMMARY, 32'h0000_0003);
        wb(`ISIO_IDX_LINE2_CTRL, 1'b1, 16'h0800);
        settle;
        chkb(1'b0, lvl2, "line two");
        wb(`ISIO_IDX_LINE1_CTRL, 1'b1, 16'h0600);
        settle;
        chkb(1'b0, lvl1, "line one");
        f1 <= 32'h0000_0000;
        settle;
        chkb(1'b1, lvl1, "line one");
        chkb(1'b0, l1_oe, "line one enable");
        chkb(1'b0, l2_oe, "line two enable");
        wb(`ISIO_IDX_EV_ENABLE, 1'b1, 16'h0004);
        wb(`ISIO_IDX_EV_CLEAR, 1'b1, 16'hFFFF);
        settle;
        chkb(1'b0, irq_o, "irq");
        ev(5'h00, 3'h0);
        ev(5'h01, 3'h1);
        settle;
        chkb(1'b1, irq_o, "irq");
        chk(`ISIO_IDX_EV_STATUS, 32'h0000_0004);
        wb(`ISIO_IDX_EV_ENABLE, 1'b1, 16'h0000);
        settle;
        chkb(1'b0, irq_o, "irq");
        // A second reset in mid-run must bring both controls back.
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(`ISIO_IDX_LINE1_CTRL, 32'h0000_0400);
        chk(`ISIO_IDX_LINE2_CTRL, 32'h0000_0000);
        chk(`ISIO_IDX_SUMMARY, 32'h0000_0002);
        settle;
        chkb(1'b0, lvl2, "line two");
        chkb(1'b1, lvl1, "line one");
        stop_test;
    end
endmodule
